// [pkg/mti_cfg.svh]
// Timing and encoding constants of the multiplier transfer interlock.
`ifndef MTI_CFG_SVH
`define MTI_CFG_SVH
`define MTI_CLK_PERIOD_NS 50
`define MTI_MUL_BUSY_CYCLES 2'h2
`define MTI_BUSY_ZERO 2'h0
`define MTI_BUSY_ONE 2'h1
`endif

// [pkg/mti_pkg.sv]
// Types shared by the multiplier transfer interlock.
package mti_pkg;
  typedef enum logic [1:0] {
    MTI_OP_OTHER = 2'h0,
    MTI_OP_MUL_WORD = 2'h1,
    MTI_OP_MAC_STORE = 2'h2,
    MTI_OP_MAC_LOAD = 2'h3
  } mti_op_t;

  typedef struct packed {
    logic valid;
    mti_op_t op;
  } mti_stage_t;

  typedef enum logic [1:0] {
    MTI_ST_IDLE = 2'h0,
    MTI_ST_WAIT = 2'h1,
    MTI_ST_ACCESS = 2'h2
  } mti_state_t;
endpackage : mti_pkg

// [rtl/mti_busy_counter.sv]
// Down counter that models the multiplier busy period.
`timescale 1ns/1ps
`default_nettype none
`include "mti_cfg.svh"
module mti_busy_counter (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control.
  input wire logic start_i,
  // Status.
  output logic busy_o,
  output logic last_o
);
  logic [1:0] count;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count <= `MTI_BUSY_ZERO;
    end else if (start_i) begin
      count <= `MTI_MUL_BUSY_CYCLES;
    end else if (count != `MTI_BUSY_ZERO) begin
      count <= count - `MTI_BUSY_ONE;
    end
  end

  assign busy_o = (count != `MTI_BUSY_ZERO);
  assign last_o = (count == `MTI_BUSY_ONE);
endmodule : mti_busy_counter
`default_nettype wire

// [rtl/mti_interlock.sv]
// Interlock for MAC transfers that follow a signed word multiply.
`timescale 1ns/1ps
`default_nettype none
`include "mti_cfg.svh"
// Overview of operation
// RL1: A MAC store to memory gets an access stage reading multiplier and writing memory.
// RL2: The MAC store access stage and instruction fetch never share one slot.
// RL3: A MAC load from a general register gets an access stage reaching the multiplier.
// RL4: A MAC load access meeting a busy multiplier is held until it finishes.
// RL5: The MAC load access stage is arbitrated against instruction fetch.
// RL6: Access and fetch contention splits the slot; later stages shift behind it.
// RL7: A word multiply busies the multiplier two cycles; a MAC store waits likewise.
module mti_interlock (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Instruction leaving the execute stage.
  input wire mti_pkg::mti_stage_t execute_stage_i,
  // Instruction fetch request from the front end.
  input wire logic fetch_req_i,
  // Access stage of a MAC transfer.
  output logic access_active_o,
  output logic access_mul_read_o,
  output logic access_mem_write_o,
  output logic access_mac_write_o,
  // Pipeline control.
  output logic fetch_grant_o,
  output logic pipe_stall_o,
  output logic multiplier_busy_o
);
  // Transfer state and the operation that it carries.
  mti_pkg::mti_state_t state;
  mti_pkg::mti_state_t next_state;
  mti_pkg::mti_op_t held_op;
  // Decoded view of the instruction leaving the execute stage.
  logic is_mul;
  logic is_store;
  logic is_load;
  logic enter;
  // Multiplier busy period.
  logic mul_start;
  logic busy;
  logic busy_last;
  logic need_mul;
  // Slot sharing between the access stage and instruction fetch.
  logic fire;
  logic fetch_served;
  logic next_fetch_served;
  logic next_fetch_grant;
  logic next_stall;
  logic next_mul_busy;

  assign is_mul = execute_stage_i.valid &&
                  execute_stage_i.op == mti_pkg::MTI_OP_MUL_WORD; // RL7
  assign is_store = execute_stage_i.valid &&
                    execute_stage_i.op == mti_pkg::MTI_OP_MAC_STORE; // RL1
  assign is_load = execute_stage_i.valid &&
                   execute_stage_i.op == mti_pkg::MTI_OP_MAC_LOAD; // RL3
  assign enter = is_store || is_load; // RL1 RL3
  // The multiplier is free once only its final busy cycle remains.
  assign need_mul = busy && !busy_last; // RL4 RL7
  // A multiply that arrives while a transfer is in flight is ignored.
  assign mul_start = is_mul && (state == mti_pkg::MTI_ST_IDLE); // RL7

  mti_busy_counter u_busy (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(mul_start),
    .busy_o(busy),
    .last_o(busy_last)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      mti_pkg::MTI_ST_IDLE: begin
        if (enter) begin
          next_state = need_mul ? mti_pkg::MTI_ST_WAIT
                                : mti_pkg::MTI_ST_ACCESS; // RL4 RL7
        end
      end
      mti_pkg::MTI_ST_WAIT: begin
        if (!need_mul) begin
          next_state = mti_pkg::MTI_ST_ACCESS; // RL4 RL7
        end
      end
      mti_pkg::MTI_ST_ACCESS: begin
        // Fetch takes the first contended slot; the access takes the next.
        if (!fetch_req_i || fetch_served) begin
          next_state = mti_pkg::MTI_ST_IDLE; // RL2 RL5 RL6
        end
      end
      default: begin
        next_state = mti_pkg::MTI_ST_IDLE;
      end
    endcase
  end

  // The access stage owns the slot in which the transfer leaves ACCESS.
  assign fire = (state == mti_pkg::MTI_ST_ACCESS) &&
                (next_state == mti_pkg::MTI_ST_IDLE); // RL2 RL5 RL6

  // Next values of the slot bookkeeping and the pipeline control outputs.
  always_comb begin
    next_fetch_served = (state == mti_pkg::MTI_ST_ACCESS) && !fire; // RL6
    next_fetch_grant = fetch_req_i && !fire; // RL2 RL5 RL6
    next_stall = (next_state != mti_pkg::MTI_ST_IDLE); // RL6
    next_mul_busy = mul_start || need_mul; // RL7
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= mti_pkg::MTI_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      held_op <= mti_pkg::MTI_OP_OTHER;
    end else if (state == mti_pkg::MTI_ST_IDLE && enter) begin
      held_op <= execute_stage_i.op;
    end
  end

  // Remembers that fetch already took one contended slot of this access.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fetch_served <= 1'b0;
    end else begin
      fetch_served <= next_fetch_served; // RL6
    end
  end

  // The grant is dropped in the access slot, so the two never overlap.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fetch_grant_o <= 1'b0;
    end else begin
      fetch_grant_o <= next_fetch_grant; // RL2 RL5 RL6
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      access_active_o <= 1'b0;
    end else if (fire) begin
      access_active_o <= 1'b1; // RL1 RL3
    end else begin
      access_active_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      access_mul_read_o <= 1'b0;
    end else if (fire && held_op == mti_pkg::MTI_OP_MAC_STORE) begin
      access_mul_read_o <= 1'b1; // RL1
    end else begin
      access_mul_read_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      access_mem_write_o <= 1'b0;
    end else if (fire && held_op == mti_pkg::MTI_OP_MAC_STORE) begin
      access_mem_write_o <= 1'b1; // RL1
    end else begin
      access_mem_write_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      access_mac_write_o <= 1'b0;
    end else if (fire && held_op == mti_pkg::MTI_OP_MAC_LOAD) begin
      access_mac_write_o <= 1'b1; // RL3
    end else begin
      access_mac_write_o <= 1'b0;
    end
  end

  // Younger instructions shift later while the transfer is in flight.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pipe_stall_o <= 1'b0;
    end else begin
      pipe_stall_o <= next_stall; // RL6
    end
  end

  // Registered so that the busy flag comes straight from a flip-flop.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      multiplier_busy_o <= 1'b0;
    end else begin
      multiplier_busy_o <= next_mul_busy; // RL7
    end
  end
endmodule : mti_interlock
`default_nettype wire

// [test/mti_interlock_sva.sv]
// Checker of the multiplier transfer interlock.
`timescale 1ns/1ps
`default_nettype none
module mti_interlock_sva (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire mti_pkg::mti_stage_t execute_stage_i,
  input wire logic fetch_req_i,
  input wire logic access_active_o,
  input wire logic access_mul_read_o,
  input wire logic access_mem_write_o,
  input wire logic access_mac_write_o,
  input wire logic fetch_grant_o,
  input wire logic pipe_stall_o,
  input wire logic multiplier_busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic take;
  mti_pkg::mti_op_t op;
  assign take = execute_stage_i.valid && !pipe_stall_o && !access_active_o;
  assign op = execute_stage_i.op;
  a_store_access_time: assert property (
    take && op == mti_pkg::MTI_OP_MAC_STORE && !multiplier_busy_o ##1
    !fetch_req_i |=> access_mem_write_o && access_mul_read_o)
    else $error("store access missing");
  a_store_after_mul: assert property (
    take && op == mti_pkg::MTI_OP_MAC_STORE && $rose(multiplier_busy_o) ##2
    !fetch_req_i |=> access_mem_write_o && access_mul_read_o)
    else $error("stretched store access missing");
  a_no_shared_slot: assert property (
    !(access_active_o && fetch_grant_o)) else $error("slot shared");
  a_load_access_time: assert property (
    take && op == mti_pkg::MTI_OP_MAC_LOAD && !multiplier_busy_o ##1
    !fetch_req_i |=> access_mac_write_o && !access_mem_write_o)
    else $error("load access missing");
  a_load_after_mul: assert property (
    take && op == mti_pkg::MTI_OP_MAC_LOAD && $rose(multiplier_busy_o) ##2
    !fetch_req_i |=> access_mac_write_o && !access_mem_write_o)
    else $error("stretched load access missing");
  a_load_waits_busy: assert property (
    access_mac_write_o |-> !multiplier_busy_o) else $error("load early");
  a_load_fetch_apart: assert property (
    access_mac_write_o |-> access_active_o && !fetch_grant_o)
    else $error("load slot wrong");
  a_stall_to_access: assert property (
    $fell(pipe_stall_o) |-> access_active_o) else $error("stall end");
  a_mul_busy_two: assert property (
    take && op == mti_pkg::MTI_OP_MUL_WORD && !multiplier_busy_o |=>
    multiplier_busy_o[*2] ##1 !multiplier_busy_o) else $error("busy span");
endmodule : mti_interlock_sva
bind mti_interlock mti_interlock_sva u_sva (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .execute_stage_i(execute_stage_i),
  .fetch_req_i(fetch_req_i), .access_active_o(access_active_o),
  .access_mul_read_o(access_mul_read_o),
  .access_mem_write_o(access_mem_write_o),
  .access_mac_write_o(access_mac_write_o), .fetch_grant_o(fetch_grant_o),
  .pipe_stall_o(pipe_stall_o), .multiplier_busy_o(multiplier_busy_o));
`default_nettype wire

// [test/test_mti_interlock.sv]
// Testbench of the multiplier transfer interlock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t access mismatch", $time); end end
module test_mti_interlock;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fetch_req_i = 1'b0;
  mti_pkg::mti_stage_t ex = '0;
  logic act, rd, wr, mw, fg, st, bz;
  int error_cnt = 0;
  int n_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  mti_interlock u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .execute_stage_i(ex), .fetch_req_i(fetch_req_i), .access_active_o(act),
    .access_mul_read_o(rd), .access_mem_write_o(wr),
    .access_mac_write_o(mw), .fetch_grant_o(fg), .pipe_stall_o(st),
    .multiplier_busy_o(bz));
  // A fetch in the slot pushes the access one cycle later.
  task automatic xfer(input mti_pkg::mti_op_t m, input mti_pkg::mti_op_t o,
      input logic f, input int n, input logic w);
    logic busy_exp;
    busy_exp = (m == mti_pkg::MTI_OP_MUL_WORD);
    @(posedge clk_sys_i);
    ex <= '{1'b1, m};
    fetch_req_i <= 1'b0;
    @(posedge clk_sys_i);
    ex <= '{1'b1, o};
    fetch_req_i <= f;
    @(posedge clk_sys_i);
    ex <= '0;
    @(negedge clk_sys_i);
    `CHK({st, act, bz, fg}, {1'b1, 1'b0, busy_exp, f})
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK(act, 1'b1)
    `CHK({rd, wr, mw}, {w, w, ~w})
    `CHK({fg, st, bz}, 3'h0)
  endtask : xfer
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    xfer(mti_pkg::MTI_OP_OTHER, mti_pkg::MTI_OP_MAC_STORE,
         1'b0, 1, 1'b1);
    xfer(mti_pkg::MTI_OP_MUL_WORD, mti_pkg::MTI_OP_MAC_STORE,
         1'b0, 2, 1'b1);
    xfer(mti_pkg::MTI_OP_MUL_WORD, mti_pkg::MTI_OP_MAC_LOAD,
         1'b0, 2, 1'b0);
    xfer(mti_pkg::MTI_OP_OTHER, mti_pkg::MTI_OP_MAC_LOAD,
         1'b1, 2, 1'b0);
    xfer(mti_pkg::MTI_OP_MUL_WORD, mti_pkg::MTI_OP_MAC_STORE,
         1'b1, 3, 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_mti_interlock
`default_nettype wire
